// >>> common/irq_halt_pkg.sv
// Package for the interrupt priority and halt/wake controller.
// Assumes one 100 MHz clock that stands for the main oscillator.
package irq_halt_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SENS   = 8'h04;
  localparam logic [7:0] OFS_PIN_IE = 8'h08;
  localparam logic [7:0] OFS_PEND   = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Control register fields
  localparam int CTRL_TBIE    = 0;
  localparam int CTRL_IMASK   = 1;
  localparam int CTRL_WDG_EN  = 2;
  localparam int CTRL_WDG_OPT = 3;
  localparam int CTRL_CSS_IE  = 4;

  // Status register fields
  localparam int STAT_MODE  = 0;
  localparam int STAT_IMASK = 5;
  localparam int STAT_TB    = 6;
  localparam int STAT_CSS   = 7;
  localparam int STAT_EXT   = 8;
  localparam int STAT_SLOT  = 16;

  // Reset values
  localparam logic       IMASK_RST  = 1'b1;
  localparam logic [7:0] SENS_RST   = 8'h00;
  localparam logic [3:0] NO_SLOT    = 4'hf;

  // Vectors and source slots
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] VEC_SLOT0 = 16'hfffa;
  localparam int NUM_SLOTS = 14;
  localparam int SLOT_TB   = 1;
  localparam int SLOT_EXT0 = 2;
  localparam int SLOT_PER0 = 7;
  localparam int NUM_EXT   = 4;
  localparam int NUM_PER   = 5;
  localparam int NUM_PINS  = 15;
  localparam int GRP_LO [NUM_EXT] = '{0, 4, 7, 11};
  localparam int GRP_W  [NUM_EXT] = '{4, 3, 4, 4};

  // Timing: wake delay in CPU cycles, oscillator cycles per CPU cycle
  localparam int WAKE_CPU_CYCLES = 4096;
  localparam int OSC_PER_CPU     = 2;
  localparam int WAKE_CLKS       = WAKE_CPU_CYCLES * OSC_PER_CPU;
  localparam int CNT_W           = 14;

  // External sensitivity codes
  localparam logic [1:0] SENS_FALL_LOW = 2'b00;
  localparam logic [1:0] SENS_RISE     = 2'b01;
  localparam logic [1:0] SENS_FALL     = 2'b10;
  localparam logic [1:0] SENS_BOTH     = 2'b11;

  typedef enum logic [4:0] {
    M_RUN   = 5'b00001,
    M_WAIT  = 5'b00010,
    M_HALT  = 5'b00100,
    M_AHALT = 5'b01000,
    M_WAKE  = 5'b10000
  } mode_t;

  typedef struct packed {
    logic prev;
    logic latch;
  } ext_state_t;

  typedef struct packed {
    mode_t                mode;
    logic                 i_mask;
    logic                 tbie;
    logic                 css_ie;
    logic                 wdg_en;
    logic                 wdg_opt;
    logic [7:0]           sens;
    logic [NUM_PINS-1:0]  pin_ie;
    logic [NUM_PER-1:0]   per_latch;
    logic [NUM_PER-1:0]   per_flag_d;
    logic                 tb_latch;
    logic                 css_latch;
    logic                 trap_pend;
    logic                 reset_pend;
    logic [CNT_W-1:0]     wake_cnt;
    logic                 tick;
    logic                 irq_take;
    logic                 stack_save;
    logic                 stack_restore;
    logic [15:0]          vector;
    logic                 wdg_rst;
    logic                 osc_run;
    logic                 tb_run;
    logic                 per_run;
    logic                 cpu_run;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } ctl_state_t;

endpackage

// >>> design/ext_irq_detect.sv
// One external interrupt group: AND of enabled pins, then detector.
// Assumes pins synchronous to CLOCK; ack is a one-cycle pulse.
`timescale 1ns/1ps
module ext_irq_detect
  import irq_halt_pkg::*;
#(
  parameter int W = 4
)(
  input  wire logic         CLOCK,
  input  wire logic         RST_B,
  input  wire logic [W-1:0] pins,
  input  wire logic [W-1:0] pin_ie,
  input  wire logic [1:0]   sens,
  input  wire logic         ack,
  output logic              req
);

  ext_state_t s_reg;
  ext_state_t s_next;
  logic       any_en;
  logic       lvl;
  logic       rise;
  logic       fall;
  logic       edge_hit;

  assign any_en = |pin_ie;
  assign lvl    = &(pins | ~pin_ie);
  assign rise   = any_en & lvl & ~s_reg.prev;
  assign fall   = any_en & ~lvl & s_reg.prev;

  always_comb
  begin
    s_next      = s_reg;
    s_next.prev = lvl;
    unique case (sens)
      SENS_RISE:     edge_hit = rise;
      SENS_FALL:     edge_hit = fall;
      SENS_BOTH:     edge_hit = rise | fall;
      SENS_FALL_LOW: edge_hit = fall;
    endcase
    if (ack)
      s_next.latch = 1'b0;
    // Set wins so an edge during ack survives
    if (edge_hit)
      s_next.latch = 1'b1;
  end

  // Low enabled pin holds level low, blocking rise
  assign req = s_reg.latch | (sens == SENS_FALL_LOW && any_en && !lvl);

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      s_reg <= '{prev: 1'b1, latch: 1'b0};
    else
      s_reg <= s_next;
  end

endmodule

// >>> design/irq_halt_ctrl.sv
// Interrupt priority, vectoring and halt/active-halt/wait control.
// Assumes CPU strobes are one-cycle pulses synchronous to CLOCK.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module irq_halt_ctrl
  import irq_halt_pkg::*;
#(
  parameter int WAKE_DELAY = WAKE_CLKS
)(
  input  wire logic               CLOCK,
  input  wire logic               RST_B,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic [31:0]             PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               RESET_REQ,
  input  wire logic               CPU_INSTR_END,
  input  wire logic               CPU_TRAP,
  input  wire logic               CPU_HALT,
  input  wire logic               CPU_WFI,
  input  wire logic               CPU_RETURN_FROM_IRQ_INSTR,
  input  wire logic               TB_EVENT,
  input  wire logic               CSS_EVENT,
  input  wire logic [NUM_PER-1:0] PERIPH_FLAG,
  input  wire logic [NUM_PER-1:0] PERIPH_EN,
  input  wire logic [NUM_PER-1:0] PERIPH_CLR,
  input  wire logic [3:0]         PIN_A,
  input  wire logic [2:0]         PIN_F,
  input  wire logic [7:0]         PIN_B,
  output logic                    I_MASK,
  output logic                    IRQ_TAKE,
  output logic [15:0]             VECTOR,
  output logic                    STACK_SAVE,
  output logic                    STACK_RESTORE,
  output logic                    CPU_TICK,
  output logic                    CPU_RUN,
  output logic                    OSC_RUN,
  output logic                    TB_RUN,
  output logic                    PERIPH_RUN,
  output logic                    WDG_RESET,
  output logic [4:0]              MODE
);

  ctl_state_t            s_reg;
  ctl_state_t            s_next;
  logic [NUM_PINS-1:0]   pin_all;
  logic [NUM_EXT-1:0]    ext_req;
  logic [NUM_EXT-1:0]    ext_ack;
  logic [NUM_SLOTS-1:0]  req;
  logic [NUM_SLOTS-1:0]  masked;
  logic [3:0]            win;
  logic [3:0]            req_top;
  logic                  take_slot;
  logic                  take_trap;
  logic                  take_reset;
  logic                  halt_wake;
  logic                  wr_pend;
  logic                  acc;
  logic                  setup_rd;
  logic [NUM_PER-1:0]    per_rise;

  // Lowest slot number wins among requests
  function automatic logic [3:0] prio(input logic [NUM_SLOTS-1:0] r);
    logic [3:0] idx;
    idx = NO_SLOT;
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
    begin
      if (r[i])
        idx = 4'(i);
    end
    return idx;
  endfunction

  assign pin_all = {PIN_B, PIN_F, PIN_A};

  // One detector per external pin group
  for (genvar g = 0; g < NUM_EXT; g++)
  begin : g_ext
    ext_irq_detect #(
      .W (GRP_W[g])
    ) u_det (
      .CLOCK  (CLOCK),
      .RST_B  (RST_B),
      .pins   (pin_all[GRP_LO[g] +: GRP_W[g]]),
      .pin_ie (s_reg.pin_ie[GRP_LO[g] +: GRP_W[g]]),
      .sens   (s_reg.sens[2*g +: 2]),
      .ack    (ext_ack[g]),
      .req    (ext_req[g])
    );
    assign ext_ack[g] = take_slot && win == 4'(SLOT_EXT0 + g);
  end

  // Time base and clock security on one slot
  always_comb
  begin
    req = '0;
    req[SLOT_TB] = (s_reg.tb_latch & s_reg.tbie) | (s_reg.css_latch & s_reg.css_ie);
    req[SLOT_EXT0 +: NUM_EXT] = ext_req;
    req[SLOT_PER0 +: NUM_PER] = s_reg.per_latch & PERIPH_EN;
  end

  // Maskable requests blocked by mask bit
  assign masked = s_reg.i_mask ? '0 : req;
  assign win    = prio(masked);
  assign req_top = prio(req);

  // Reset pending beats everything in run
  assign take_reset = s_reg.mode == M_RUN && s_reg.reset_pend;
  assign take_trap  = s_reg.mode == M_RUN && !s_reg.reset_pend && CPU_INSTR_END
                      && s_reg.trap_pend;
  // Taken only at an instruction boundary
  assign take_slot  = s_reg.mode == M_RUN && !s_reg.reset_pend && CPU_INSTR_END
                      && !s_reg.trap_pend && win != NO_SLOT;

  // Halt exit: reset, slot one, external only
  assign halt_wake = RESET_REQ | s_reg.reset_pend | req[SLOT_TB] | (|ext_req);

  // APB: zero-wait-state free, one wait cycle
  assign setup_rd = PSEL && PENABLE && !s_reg.pready;
  assign acc      = PSEL && PENABLE && s_reg.pready;
  assign wr_pend  = acc && PWRITE && PADDR == OFS_PEND;
  assign per_rise = PERIPH_FLAG & ~s_reg.per_flag_d;

  always_comb
  begin
    s_next               = s_reg;
    s_next.irq_take      = 1'b0;
    s_next.stack_save    = 1'b0;
    s_next.stack_restore = 1'b0;
    s_next.wdg_rst       = 1'b0;
    s_next.pready        = setup_rd;
    s_next.pslverr       = 1'b0;
    s_next.per_flag_d    = PERIPH_FLAG;

    // APB read data captured in the wait cycle
    if (setup_rd)
    begin
      s_next.prdata = '0;
      unique case (PADDR)
        OFS_CTRL:
        begin
          s_next.prdata[CTRL_TBIE]    = s_reg.tbie;
          s_next.prdata[CTRL_IMASK]   = s_reg.i_mask;
          s_next.prdata[CTRL_WDG_EN]  = s_reg.wdg_en;
          s_next.prdata[CTRL_WDG_OPT] = s_reg.wdg_opt;
          s_next.prdata[CTRL_CSS_IE]  = s_reg.css_ie;
        end
        OFS_SENS:   s_next.prdata[7:0] = s_reg.sens;
        OFS_PIN_IE: s_next.prdata[NUM_PINS-1:0] = s_reg.pin_ie;
        OFS_PEND:   s_next.prdata[NUM_PER-1:0] = s_reg.per_latch;
        OFS_STATUS:
        begin
          s_next.prdata[STAT_MODE +: 5]       = s_reg.mode;
          s_next.prdata[STAT_IMASK]           = s_reg.i_mask;
          s_next.prdata[STAT_TB]              = s_reg.tb_latch;
          s_next.prdata[STAT_CSS]             = s_reg.css_latch;
          s_next.prdata[STAT_EXT +: NUM_EXT]  = ext_req;
          s_next.prdata[STAT_SLOT +: 4]       = req_top;
        end
        default:    s_next.pslverr = 1'b1;
      endcase
    end

    // Writes land on the completing edge only
    if (acc && PWRITE)
    begin
      unique case (PADDR)
        OFS_CTRL:
        begin
          s_next.tbie    = PWDATA[CTRL_TBIE];
          s_next.i_mask  = PWDATA[CTRL_IMASK];
          s_next.wdg_en  = PWDATA[CTRL_WDG_EN];
          s_next.wdg_opt = PWDATA[CTRL_WDG_OPT];
          s_next.css_ie  = PWDATA[CTRL_CSS_IE];
        end
        OFS_SENS:   s_next.sens = PWDATA[7:0];
        OFS_PIN_IE: s_next.pin_ie = PWDATA[NUM_PINS-1:0];
        default:    s_next.pin_ie = s_reg.pin_ie;
      endcase
    end

    // Zero write or clear sequence drops latch
    s_next.per_latch = s_reg.per_latch & ~PERIPH_CLR;
    if (wr_pend)
      s_next.per_latch = s_next.per_latch & PWDATA[NUM_PER-1:0];
    // A flag edge in the clearing cycle is kept
    s_next.per_latch = s_next.per_latch | per_rise;

    // Time base only counts while its oscillator runs
    if (TB_EVENT && s_reg.tb_run)
      s_next.tb_latch = 1'b1;
    if (CSS_EVENT)
      s_next.css_latch = 1'b1;
    if (CPU_TRAP)
      s_next.trap_pend = 1'b1;
    if (RESET_REQ)
      s_next.reset_pend = 1'b1;

    // CPU tick at half the oscillator rate
    s_next.tick = s_reg.osc_run ? ~s_reg.tick : 1'b0;

    // Return restores stack, mask ends clear
    if (CPU_RETURN_FROM_IRQ_INSTR && s_reg.mode == M_RUN)
    begin
      s_next.stack_restore = 1'b1;
      s_next.i_mask        = 1'b0;
    end

    // Every entry sets the mask bit
    if (take_reset)
    begin
      s_next.irq_take   = 1'b1;
      s_next.vector     = VEC_RESET;
      s_next.i_mask     = 1'b1;
      s_next.reset_pend = RESET_REQ;
      s_next.trap_pend  = 1'b0;
    end
    else if (take_trap || take_slot)
    begin
      s_next.irq_take   = 1'b1;
      s_next.stack_save = 1'b1;
      s_next.i_mask     = 1'b1;
      s_next.trap_pend  = take_slot ? s_next.trap_pend : CPU_TRAP;
      s_next.vector     = take_trap ? VEC_TRAP
                          : 16'(VEC_SLOT0 - {11'h000, win, 1'b0});
      // Set wins: an event in the take cycle is kept
      if (take_slot && win == 4'(SLOT_TB))
      begin
        s_next.tb_latch  = TB_EVENT && s_reg.tb_run;
        s_next.css_latch = CSS_EVENT;
      end
    end

    unique case (s_reg.mode)
      M_RUN:
      begin
        if (!RESET_REQ && !s_reg.reset_pend && CPU_HALT)
        begin
          s_next.i_mask = 1'b0;
          // Time-base enable picks the halt kind
          if (s_reg.tbie)
            s_next.mode = M_AHALT;
          else
          begin
            s_next.mode    = M_HALT;
            s_next.wdg_rst = s_reg.wdg_en & s_reg.wdg_opt;
          end
        end
        else if (!RESET_REQ && !s_reg.reset_pend && CPU_WFI)
        begin
          s_next.i_mask = 1'b0;
          s_next.mode   = M_WAIT;
        end
      end
      M_WAIT:
      begin
        // Any request or reset leaves wait
        if ((|req) || RESET_REQ || s_reg.reset_pend)
          s_next.mode = M_RUN;
      end
      M_HALT, M_AHALT:
      begin
        if (halt_wake)
        begin
          s_next.mode     = M_WAKE;
          s_next.wake_cnt = '0;
        end
      end
      M_WAKE:
      begin
        s_next.wake_cnt = s_reg.wake_cnt + 1'b1;
        if (s_reg.wake_cnt == CNT_W'(WAKE_DELAY - 1))
          s_next.mode = M_RUN;
      end
      default:
        s_next.mode = M_RUN;
    endcase

    // Clock gates follow the next mode
    s_next.osc_run = s_next.mode != M_HALT;
    s_next.tb_run  = s_next.mode != M_HALT;
    s_next.per_run = s_next.mode == M_RUN || s_next.mode == M_WAIT;
    s_next.cpu_run = s_next.mode == M_RUN;
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s_reg        <= '0;
      s_reg.mode   <= M_RUN;
      s_reg.i_mask <= IMASK_RST;
      s_reg.sens   <= SENS_RST;
      s_reg.osc_run <= 1'b1;
      s_reg.tb_run <= 1'b1;
      s_reg.per_run <= 1'b1;
      s_reg.cpu_run <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign PRDATA        = s_reg.prdata;
  assign PREADY        = s_reg.pready;
  assign PSLVERR       = s_reg.pslverr;
  assign I_MASK        = s_reg.i_mask;
  assign IRQ_TAKE      = s_reg.irq_take;
  assign VECTOR        = s_reg.vector;
  assign STACK_SAVE    = s_reg.stack_save;
  assign STACK_RESTORE = s_reg.stack_restore;
  assign CPU_TICK      = s_reg.tick;
  assign CPU_RUN       = s_reg.cpu_run;
  assign OSC_RUN       = s_reg.osc_run;
  assign TB_RUN        = s_reg.tb_run;
  assign PERIPH_RUN    = s_reg.per_run;
  assign WDG_RESET     = s_reg.wdg_rst;
  assign MODE          = s_reg.mode;

endmodule

// >>> testbench/cpu_model.sv
// CPU stand-in that marks instruction boundaries for the controller.
// Assumes the controller's run gate and mode outputs on the same clock.
`timescale 1ns/1ps
module cpu_model
(
  input  wire logic       CLOCK,
  input  wire logic       RST_B,
  input  wire logic       CPU_RUN,
  input  wire logic [4:0] MODE,
  output logic            INSTR_END
);
  logic [1:0] phase_reg;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      phase_reg <= 2'h0;
      INSTR_END <= 1'b0;
    end
    else
    begin
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      // Three-cycle instructions; a stopped core ends none
      INSTR_END <= CPU_RUN && (MODE == 5'h1) && (phase_reg == 2'h2);
    end
  end
endmodule

// >>> testbench/irq_halt_ctrl_sva.sv
// Assertion checker on the controller ports, bound at the foot.
// Assumes one clock domain reset by RST_B.
`timescale 1ns/1ps
module irq_halt_ctrl_chk
#(
  parameter int WAKE_DELAY = 8192
)(
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic        RESET_REQ,
  input wire logic        CPU_INSTR_END,
  input wire logic        CPU_TRAP,
  input wire logic        CPU_HALT,
  input wire logic        I_MASK,
  input wire logic        IRQ_TAKE,
  input wire logic [15:0] VECTOR,
  input wire logic        STACK_SAVE,
  input wire logic        CPU_TICK,
  input wire logic        CPU_RUN,
  input wire logic        OSC_RUN,
  input wire logic        TB_RUN,
  input wire logic        PERIPH_RUN,
  input wire logic [4:0]  MODE
);
  int unsigned wake_len_reg;
  default clocking dflt @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // Cycles spent in the wake delay
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      wake_len_reg <= 0;
    else
      wake_len_reg <= (MODE == 5'h10) ? wake_len_reg + 1 : 0;
  end
  sequence trap_masked;
    CPU_TRAP && I_MASK && (MODE == 5'h1);
  endsequence
  sequence trap_entered;
    ##[1:12] (IRQ_TAKE && (VECTOR == 16'hfffc));
  endsequence
  sequence halt_req;
    CPU_HALT && (MODE == 5'h1) && !RESET_REQ;
  endsequence
  sequence wake_end;
    $fell(MODE == 5'h10);
  endsequence
  AST_TAKE_MASK: assert property (IRQ_TAKE |-> I_MASK)
    else $error("mask clear at entry");
  AST_VEC_MAP: assert property (IRQ_TAKE |-> VECTOR inside {16'hfffe, 16'hfffc,
    16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffec, 16'hffea, 16'hffe8,
    16'hffe6, 16'hffe4}) else $error("vector off the map");
  AST_RESET_VEC: assert property (IRQ_TAKE |-> (VECTOR == 16'hfffe) == !STACK_SAVE)
    else $error("reset entry pushed state");
  AST_TRAP: assert property (trap_masked |-> trap_entered)
    else $error("trap not entered");
  AST_EXT_UNMASKED: assert property (IRQ_TAKE && VECTOR[15:3] == 13'h1ffe |-> !$past(I_MASK))
    else $error("external entry while masked");
  AST_BOUNDARY: assert property (IRQ_TAKE && STACK_SAVE |-> $past(CPU_INSTR_END))
    else $error("entry off a boundary");
  AST_HALT_MASK: assert property (halt_req |=> (MODE == 5'h4 || MODE == 5'h8) && !I_MASK)
    else $error("halt entry wrong");
  AST_HALT_CLK: assert property (MODE == 5'h4 |-> !OSC_RUN && !CPU_RUN && !PERIPH_RUN)
    else $error("clock runs in halt");
  AST_AHALT_CLK: assert property (MODE == 5'h8 |-> OSC_RUN && TB_RUN && !CPU_RUN && !PERIPH_RUN)
    else $error("active halt gating wrong");
  AST_WAKE_LEN: assert property (wake_end |-> wake_len_reg == WAKE_DELAY)
    else $error("wake delay length");
  AST_WAKE_RUN: assert property (wake_end |-> MODE == 5'h1 && CPU_RUN)
    else $error("no run after wake");
  AST_TICK_HALF: assert property ($past(RST_B) && OSC_RUN && $past(OSC_RUN) && $past(OSC_RUN, 2)
    |-> CPU_TICK != $past(CPU_TICK)) else $error("cpu tick not halved");
endmodule

bind irq_halt_ctrl irq_halt_ctrl_chk #(.WAKE_DELAY(WAKE_DELAY)) chk (
  .CLOCK(CLOCK), .RST_B(RST_B), .RESET_REQ(RESET_REQ), .CPU_INSTR_END(CPU_INSTR_END),
  .CPU_TRAP(CPU_TRAP), .CPU_HALT(CPU_HALT), .I_MASK(I_MASK), .IRQ_TAKE(IRQ_TAKE),
  .VECTOR(VECTOR), .STACK_SAVE(STACK_SAVE), .CPU_TICK(CPU_TICK), .CPU_RUN(CPU_RUN),
  .OSC_RUN(OSC_RUN), .TB_RUN(TB_RUN), .PERIPH_RUN(PERIPH_RUN), .MODE(MODE)
);

// >>> testbench/testbench.sv
// Self-checking bench for the interrupt and halt controller.
// Assumes the CPU stand-in model and the bound checker.
`timescale 1ns/1ps
module testbench
  import irq_halt_pkg::*;
;
  localparam int WD = 16;
  localparam int TRP = 0;
  localparam int HLT = 1;
  localparam int WFI = 2;
  localparam int RET = 3;
  localparam int TBE = 4;
  localparam int RRQ = 5;
  localparam int CSE = 6;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, wdg;
  logic        irq_take, stack_save, stack_restore, i_mask, cpu_run, instr_end;
  logic [7:0]  paddr, pin_b;
  logic [31:0] pwdata, prdata;
  logic [6:0]  stb;
  logic [4:0]  pflag, pen, pclr, mode, en_r, dis, lo;
  logic [3:0]  pin_a;
  logic [2:0]  pin_f;
  logic [15:0] vector, ev;
  logic [33:0] er;
  logic [15:0] vq[$];
  logic [33:0] rq[$];
  int          err_count, checks, wdg_n, seed, ret_n, ret_x;

  irq_halt_ctrl #(.WAKE_DELAY(WD)) dut (
    .CLOCK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RESET_REQ(stb[RRQ]), .CPU_INSTR_END(instr_end), .CPU_TRAP(stb[TRP]),
    .CPU_HALT(stb[HLT]), .CPU_WFI(stb[WFI]), .CPU_RETURN_FROM_IRQ_INSTR(stb[RET]), .TB_EVENT(stb[TBE]),
    .CSS_EVENT(stb[CSE]), .PERIPH_FLAG(pflag), .PERIPH_EN(pen), .PERIPH_CLR(pclr),
    .PIN_A(pin_a), .PIN_F(pin_f), .PIN_B(pin_b), .I_MASK(i_mask), .IRQ_TAKE(irq_take),
    .VECTOR(vector), .STACK_SAVE(stack_save), .STACK_RESTORE(stack_restore), .CPU_TICK(),
    .CPU_RUN(cpu_run), .OSC_RUN(), .TB_RUN(), .PERIPH_RUN(), .WDG_RESET(wdg), .MODE(mode)
  );
  cpu_model cpu (.CLOCK(clk), .RST_B(rst_b), .CPU_RUN(cpu_run), .MODE(mode),
    .INSTR_END(instr_end));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tout(input string n);
    err_count++;
    $display("mismatch %s expected done seen timeout", n);
    end_sim();
  endtask

  task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] s);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Called just after a rising edge; waits out the wait states
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    int k;
    rq.push_back(x);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    @(posedge clk);
    // Pready read at the edge, before that edge updates it
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      k++;
      if (k > 20)
        tout("pready");
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input int b);
    if (b == RET)
      ret_x++;
    stb[b] <= 1'b1;
    @(posedge clk);
    stb <= 7'h0;
    @(posedge clk);
  endtask

  task automatic drain;
    int k;
    k = 0;
    while (vq.size() != 0)
    begin
      @(negedge clk);
      k++;
      if (k > 200)
        tout("take");
    end
    @(posedge clk);
  endtask

  // Leave the running routine, await the next entry, clear its source if it is a peripheral
  task automatic serve(input logic [15:0] v);
    vq.push_back(v);
    pulse(RET);
    drain();
    if (v <= 16'hffec)
    begin
      pclr <= 5'(5'h1 << ((16'hffec - v) >> 1));
      @(posedge clk);
      pclr <= 5'h0;
      @(posedge clk);
    end
  endtask

  always @(negedge clk)
  begin
    if (wdg === 1'b1)
      wdg_n++;
    if (stack_restore === 1'b1)
      ret_n++;
    if (irq_take === 1'b1)
    begin
      ev = (vq.size() != 0) ? vq.pop_front() : 16'h0;
      cmp("vector", {17'h0, ev != VEC_RESET, ev}, {17'h0, stack_save, vector});
    end
    if (pready === 1'b1)
    begin
      er = (rq.size() != 0) ? rq.pop_front() : 34'h0;
      cmp("apb", {1'b0, er[32], er[33] ? er[31:0] : prdata}, {1'b0, pslverr, prdata});
    end
  end

  initial
  begin
    {psel, penable, pwrite, stb, pclr, pflag, pen, paddr, pwdata} = '0;
    {pin_a, pin_f, pin_b} = 15'h7ffc;
    rst_b = 1'b0;
    err_count = 0;
    checks = 0;
    wdg_n = 0;
    ret_n = 0;
    ret_x = 0;
    seed = $urandom(2612);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    cmp("mode", 34'h1, {29'h0, mode});
    @(posedge clk);
    apb(1'b0, OFS_CTRL, 32'h0, {2'b10, 32'h2});
    apb(1'b0, 8'h14, 32'h0, {2'b11, 32'h0});
    vq.push_back(VEC_TRAP);
    pulse(TRP);
    drain();
    apb(1'b0, OFS_STATUS, 32'h0, {2'b10, 32'h000f0021});
    // Arm time base, clock security, one pin per group (two in the third) and the en_r peripherals while the trap routine keeps the mask set
    apb(1'b1, OFS_CTRL, 32'h13, 34'h0);
    apb(1'b1, OFS_SENS, 32'h1e, 34'h0);
    apb(1'b1, OFS_PIN_IE, 32'h991, 34'h0);
    en_r = 5'(($urandom % 31) + 1);
    pen <= en_r;
    pflag <= 5'h1f;
    pin_a[0] <= 1'b0;
    pin_b[0] <= 1'b1;
    pulse(TBE);
    serve(16'hfff8);
    // Clock security shares the time-base slot
    pulse(CSE);
    serve(16'hfff8);
    serve(16'hfff6);
    for (int i = 0; i < 5; i++)
      if (en_r[i])
        serve(16'hffec - 16'(2 * i));
    dis = ~en_r;
    lo = dis & (~dis + 5'h1);
    apb(1'b1, OFS_PEND, {27'h0, ~lo}, 34'h0);
    apb(1'b0, OFS_PEND, 32'h0, {2'b10, 27'h0, dis & ~lo});
    pen <= 5'h1f;
    for (int i = 0; i < 5; i++)
      if (dis[i] && !lo[i])
        serve(16'hffec - 16'(2 * i));
    // Second pin of the group was low, so only its rise may request
    pin_b[1] <= 1'b1;
    serve(16'hfff2);
    pulse(RET);
    @(negedge clk);
    cmp("mask", 34'h0, {33'h0, i_mask});
    @(posedge clk);
    pflag <= 5'h0;
    pen <= 5'h0;
    pulse(HLT);
    pflag[0] <= 1'b1;
    pen[0] <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    cmp("mode", 34'h8, {29'h0, mode});
    @(posedge clk);
    pen <= 5'h0;
    vq.push_back(16'hfff8);
    pulse(TBE);
    drain();
    apb(1'b1, OFS_CTRL, 32'hc, 34'h0);
    pulse(WFI);
    vq.push_back(16'hfff0);
    pin_b[4] <= 1'b0;
    drain();
    pin_b[4] <= 1'b1;
    pulse(HLT);
    vq.push_back(16'hfff4);
    pin_f[0] <= 1'b0;
    drain();
    @(negedge clk);
    cmp("wdg", 34'h1, 34'(wdg_n));
    @(posedge clk);
    pulse(RET);
    pulse(HLT);
    vq.push_back(VEC_RESET);
    pulse(RRQ);
    drain();
    cmp("restore", 34'(ret_x), 34'(ret_n));
    end_sim();
  end
endmodule
